// [rtl/flash_ctl_map.svh]
// register offsets, field positions, reset values and timing counts of the flash controller
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
`define FC_OFF_CTRL_FIRST   32'h0000_0000
`define FC_OFF_CTRL_SECOND  32'h0000_0004
`define FC_OFF_CTRL_THIRD   32'h0000_0008
`define FC_OFF_ADDR         32'h0000_000c
`define FC_OFF_DATA         32'h0000_0010
// first control: operation and interrupt options
`define FC_BIT_WRITE        0
`define FC_BIT_ERASE        1
`define FC_BIT_SUSP_INT     2
`define FC_BIT_ABORT_INT    3
`define FC_BIT_MARGINAL     4
// third control: status and protection
`define FC_BIT_BUSY         0
`define FC_BIT_EXIT         1
`define FC_BIT_LOCK_A       2
`define FC_BIT_SUSPENDED    3
`define FC_BIT_ABORTED      4
`define FC_BIT_CLK_REQ      5
`define FC_RST_FIRST        8'h00
`define FC_RST_THIRD        8'h04
// segment A window and main region it used to alias onto
`define FC_SEG_A_BASE       16'h10c0
`define FC_SEG_MASK         16'hffc0
`define FC_MAIN_ALIAS_LO    16'hfc40
`define FC_MAIN_ALIAS_HI    16'hfc7f
// timing in timing-clock ticks, synchroniser depth in stages
`define FC_WRITE_TICKS      16'h0020
`define FC_ERASE_TICKS      16'h1000
`define FC_SYNC_STAGES      2
`endif

// [rtl/flash_ctl_pkg.sv]
// types shared by the flash controller files
package flash_ctl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_WRITE   = 5'b00010,
    ST_ERASE   = 5'b00100,
    ST_SUSPEND = 5'b01000,
    ST_ABORT   = 5'b10000
  } op_state_e;
endpackage

// [rtl/flash_ctl_tick.sv]
// timing clock synchroniser, edge detect and stop watchdog
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_map.svh"
module flash_ctl_tick #(
  parameter int STOP_LIMIT = 64
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic tclk_in,
  input  wire logic req_in,
  output logic      tick_out,
  output logic      stopped_out
);
  // refuse limits the idle counter cannot count to
  if (STOP_LIMIT < 4 || STOP_LIMIT > 65535) begin : g_bad_limit
    $error("bad STOP_LIMIT");
  end
  logic [1:0]  sync_r;     // two-stage synchroniser
  logic        last_r;     // previous synced level
  logic [15:0] idle_r;     // cycles without timing edge
  // synchronise the timing clock pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], tclk_in};
    end
  end
  // rising edge makes a tick
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_r   <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      last_r   <= sync_r[1];
      tick_out <= sync_r[1] & ~last_r;
    end
  end
  // watchdog flags a stalled clock while requested
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_r      <= 16'h0;
      stopped_out <= 1'b0;
    end else if (!req_in || (sync_r[1] & ~last_r)) begin
      idle_r      <= 16'h0;
      stopped_out <= 1'b0;
    end else if (idle_r == 16'(STOP_LIMIT)) begin
      stopped_out <= 1'b1;
    end else begin
      idle_r <= idle_r + 16'h1;
    end
  end
endmodule // flash_ctl_tick
`default_nettype wire

// [rtl/flash_ctl_timer.sv]
// operation duration counter, freezes while suspended
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_map.svh"
module flash_ctl_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        load_in,
  input  wire logic [15:0] ticks_in,
  input  wire logic        run_in,
  input  wire logic        tick_in,
  output logic             done_out
);
  logic [15:0] cnt_r; // remaining ticks
  // count down on timing ticks only while running
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r    <= 16'h0;
      done_out <= 1'b0;
    end else if (load_in) begin
      cnt_r    <= ticks_in;
      done_out <= 1'b0;
    end else if (run_in && tick_in && cnt_r != 16'h0) begin
      cnt_r    <= cnt_r - 16'h1;
      done_out <= (cnt_r == 16'h1);
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule // flash_ctl_timer
`default_nettype wire

// [rtl/flash_erase_write_control.sv]
// flash write and segment erase sequencer with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_map.svh"
module flash_erase_write_control #(
  parameter int STOP_LIMIT = 64
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        TIMING_CLK_IN,
  input  wire logic        INTERRUPT_IN,
  input  wire logic        GLOBAL_INTERRUPT_ENABLE_IN,
  input  wire logic        RETURN_FROM_INTERRUPT_IN,
  output logic             PC_STALL_OUT,
  output logic             BUSY_OUT,
  output logic             TIMING_CLK_REQ_OUT,
  output logic             FLASH_WRITE_OUT,
  output logic             FLASH_ERASE_OUT,
  output logic [15:0]      FLASH_ADDR_OUT,
  output logic [7:0]       FLASH_DATA_OUT,
  output logic             MARGINAL_READ_OUT
);
  // ahb address phase capture
  logic        dp_wr_r;       // pending data-phase write
  logic        dp_rd_r;       // pending data-phase read
  logic [4:0]  dp_off_r;      // captured byte offset
  // control registers
  logic [7:0]  ctrl_first_r;  // op select and options
  logic        lock_a_r;      // segment A lock
  logic        exit_req_r;    // emergency exit pulse
  logic [15:0] addr_r;        // target address
  logic [7:0]  data_r;        // write data
  logic        aborted_r;     // last op was aborted
  // sequencer
  flash_ctl_pkg::op_state_e state_r;
  flash_ctl_pkg::op_state_e state_nxt;
  logic [1:0]  int_sync_r;    // interrupt synchroniser
  logic [1:0]  ret_sync_r;    // return synchroniser
  logic [1:0]  gie_sync_r;    // interrupt-enable synchroniser
  logic        int_last_r;    // previous interrupt level
  logic        ret_last_r;    // previous return level
  logic        start_op;      // dummy write starts op
  logic        tick;          // timing clock edge
  logic        clk_stopped;   // timing clock fault
  logic        timer_done;    // op finished
  logic        int_rise;      // new interrupt event
  logic        ret_rise;      // return-from-interrupt event
  logic        seg_a_hit;     // target inside segment A
  logic        blocked;       // locked segment A target
  // reset image of the third control register
  localparam logic [7:0] RST_THIRD = `FC_RST_THIRD;

  // edge events from the synchronised core pins
  assign int_rise  = int_sync_r[1] & ~int_last_r;
  assign ret_rise  = ret_sync_r[1] & ~ret_last_r;
  // segment A decode, gated by the lock bit
  assign seg_a_hit = ((addr_r & `FC_SEG_MASK) == `FC_SEG_A_BASE);
  assign blocked   = seg_a_hit & lock_a_r;
  // write to data register is the dummy write that starts an op
  assign start_op  = dp_wr_r && (dp_off_r == 5'(`FC_OFF_DATA)) && (state_r == flash_ctl_pkg::ST_IDLE);

  // timing clock tick source and stop watchdog
  flash_ctl_tick #(
    .STOP_LIMIT (STOP_LIMIT)
  ) u_tick (
    .clk_in      (CLK_SYS_IN),
    .rst_n_in    (RST_N_IN),
    .tclk_in     (TIMING_CLK_IN),
    .req_in      (TIMING_CLK_REQ_OUT),
    .tick_out    (tick),
    .stopped_out (clk_stopped)
  );

  // operation length in timing ticks, erase or write
  flash_ctl_timer u_timer (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RST_N_IN),
    .load_in  (start_op),
    .ticks_in (ctrl_first_r[`FC_BIT_ERASE] ? `FC_ERASE_TICKS : `FC_WRITE_TICKS),
    .run_in   (state_r == flash_ctl_pkg::ST_WRITE || state_r == flash_ctl_pkg::ST_ERASE),
    .tick_in  (tick),
    .done_out (timer_done)
  );

  // synchronise core event pins
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      int_sync_r <= 2'h0;
      ret_sync_r <= 2'h0;
      gie_sync_r <= 2'h0;
      int_last_r <= 1'b0;
      ret_last_r <= 1'b0;
    end else begin
      // first stage feeds only the second
      int_sync_r <= {int_sync_r[0], INTERRUPT_IN};
      ret_sync_r <= {ret_sync_r[0], RETURN_FROM_INTERRUPT_IN};
      gie_sync_r <= {gie_sync_r[0], GLOBAL_INTERRUPT_ENABLE_IN};
      int_last_r <= int_sync_r[1];
      ret_last_r <= ret_sync_r[1];
    end
  end

  // ahb address phase: capture accepted transfers
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dp_wr_r  <= 1'b0;
      dp_rd_r  <= 1'b0;
      dp_off_r <= 5'h0;
    end else if (HREADY_IN) begin
      dp_wr_r  <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN;
      dp_rd_r  <= HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN;
      // offset kept for the data phase
      dp_off_r <= HADDR_IN[4:0];
    end
  end

  // bus answer: zero wait, always okay
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      // no wait states and no error answers
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // register writes in data phase
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_first_r <= `FC_RST_FIRST;
      lock_a_r     <= RST_THIRD[`FC_BIT_LOCK_A];
      exit_req_r   <= 1'b0;
      addr_r       <= 16'h0;
      data_r       <= 8'h0;
    end else begin
      // exit request lasts a single cycle
      exit_req_r <= 1'b0;
      if (dp_wr_r) begin
        if (dp_off_r == 5'(`FC_OFF_CTRL_FIRST)) begin
          // op select only changes while idle
          if (state_r == flash_ctl_pkg::ST_IDLE) begin
            ctrl_first_r <= HWDATA_IN[7:0];
          end else begin
            // only the interrupt options may change mid-op
            ctrl_first_r[`FC_BIT_SUSP_INT]  <= HWDATA_IN[`FC_BIT_SUSP_INT];
            ctrl_first_r[`FC_BIT_ABORT_INT] <= HWDATA_IN[`FC_BIT_ABORT_INT];
          end
        end else if (dp_off_r == 5'(`FC_OFF_CTRL_THIRD)) begin
          // lock and exit share the third register
          lock_a_r   <= HWDATA_IN[`FC_BIT_LOCK_A];
          exit_req_r <= HWDATA_IN[`FC_BIT_EXIT];
        end else if (dp_off_r == 5'(`FC_OFF_ADDR)) begin
          // address frozen during op so resume reuses it
          if (state_r == flash_ctl_pkg::ST_IDLE) begin
            addr_r <= HWDATA_IN[15:0];
          end
        end else if (dp_off_r == 5'(`FC_OFF_DATA)) begin
          if (state_r == flash_ctl_pkg::ST_IDLE) begin
            // data byte frozen while an op runs
            data_r <= HWDATA_IN[7:0];
          end
        end
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flash_ctl_pkg::ST_IDLE: begin
        // locked target stays idle; erase wins over write
        if (start_op && ctrl_first_r[`FC_BIT_ERASE] && !blocked) begin
          state_nxt = flash_ctl_pkg::ST_ERASE;
        end else if (start_op && ctrl_first_r[`FC_BIT_WRITE] && !blocked) begin
          state_nxt = flash_ctl_pkg::ST_WRITE;
        end
      end
      flash_ctl_pkg::ST_WRITE, flash_ctl_pkg::ST_ERASE: begin
        // abort sources first, then suspend, then done
        if (exit_req_r) begin
          state_nxt = flash_ctl_pkg::ST_ABORT;
        end else if (clk_stopped) begin
          state_nxt = flash_ctl_pkg::ST_ABORT;
        end else if (int_rise && ctrl_first_r[`FC_BIT_ABORT_INT] && gie_sync_r[1]) begin
          state_nxt = flash_ctl_pkg::ST_ABORT;
        // an erase ending in this cycle is done, so no counter-less resume
        end else if (int_rise && ctrl_first_r[`FC_BIT_SUSP_INT] && state_r == flash_ctl_pkg::ST_ERASE
                     && !timer_done) begin
          state_nxt = flash_ctl_pkg::ST_SUSPEND;
        end else if (timer_done) begin
          state_nxt = flash_ctl_pkg::ST_IDLE;
        end
      end
      flash_ctl_pkg::ST_SUSPEND: begin
        // a held erase can still be aborted, else waits for return
        if (exit_req_r) begin
          state_nxt = flash_ctl_pkg::ST_ABORT;
        end else if (int_rise && ctrl_first_r[`FC_BIT_ABORT_INT] && gie_sync_r[1]) begin
          state_nxt = flash_ctl_pkg::ST_ABORT;
        end else if (ret_rise) begin
          state_nxt = flash_ctl_pkg::ST_ERASE;
        end
      end
      flash_ctl_pkg::ST_ABORT: begin
        // one cycle in abort, then idle
        state_nxt = flash_ctl_pkg::ST_IDLE;
      end
      default: begin
        // any other code falls back to idle
        state_nxt = flash_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= flash_ctl_pkg::ST_IDLE;
    end else begin
      // state advances on every edge
      state_r <= state_nxt;
    end
  end

  // aborted flag: set on abort wins over clear on new op
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aborted_r <= 1'b0;
    end else if (state_nxt == flash_ctl_pkg::ST_ABORT) begin
      aborted_r <= 1'b1;
    end else if (start_op) begin
      // a new op clears the old outcome
      aborted_r <= 1'b0;
    end
  end

  // flash array drive and core status outputs
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      // everything idle out of reset
      PC_STALL_OUT       <= 1'b0;
      BUSY_OUT           <= 1'b0;
      TIMING_CLK_REQ_OUT <= 1'b0;
      FLASH_WRITE_OUT    <= 1'b0;
      FLASH_ERASE_OUT    <= 1'b0;
      FLASH_ADDR_OUT     <= 16'h0;
      FLASH_DATA_OUT     <= 8'h0;
      MARGINAL_READ_OUT  <= 1'b0;
    end else begin
      // busy through erase and suspension
      BUSY_OUT <= (state_nxt == flash_ctl_pkg::ST_WRITE) || (state_nxt == flash_ctl_pkg::ST_ERASE)
                  || (state_nxt == flash_ctl_pkg::ST_SUSPEND);
      // stall the core only while erase runs, not while suspended
      PC_STALL_OUT <= (state_nxt == flash_ctl_pkg::ST_ERASE);
      // timing clock request drops as soon as op ends
      TIMING_CLK_REQ_OUT <= (state_nxt == flash_ctl_pkg::ST_WRITE)
                            || (state_nxt == flash_ctl_pkg::ST_ERASE);
      // array strobes follow the next state
      FLASH_WRITE_OUT <= (state_nxt == flash_ctl_pkg::ST_WRITE);
      FLASH_ERASE_OUT <= (state_nxt == flash_ctl_pkg::ST_ERASE);
      // locked segment A is refused outright, never aliased to main
      FLASH_ADDR_OUT <= blocked ? 16'h0 : addr_r;
      // data byte and marginal level for the array
      FLASH_DATA_OUT <= data_r;
      MARGINAL_READ_OUT <= ctrl_first_r[`FC_BIT_MARGINAL];
    end
  end

  // register reads
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      HRDATA_OUT <= 32'h0;
    end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
      // first control reads back as written
      if (HADDR_IN[4:0] == 5'(`FC_OFF_CTRL_FIRST)) begin
        HRDATA_OUT <= {24'h0, ctrl_first_r};
      end else if (HADDR_IN[4:0] == 5'(`FC_OFF_CTRL_THIRD)) begin
        // status: busy, lock, suspended, aborted, clock request
        HRDATA_OUT <= {26'h0, TIMING_CLK_REQ_OUT, aborted_r,
                       (state_r == flash_ctl_pkg::ST_SUSPEND), lock_a_r, 1'b0, BUSY_OUT};
      end else if (HADDR_IN[4:0] == 5'(`FC_OFF_ADDR)) begin
        // address and data read back as held
        HRDATA_OUT <= {16'h0, addr_r};
      end else if (HADDR_IN[4:0] == 5'(`FC_OFF_DATA)) begin
        HRDATA_OUT <= {24'h0, data_r};
      end else begin
        HRDATA_OUT <= 32'h0; // unmapped reads zero
      end
    end
  end
endmodule // flash_erase_write_control
`default_nettype wire

// [tb/flash_ctl_checker_assertions.sv]
// port-level checks of the flash erase and write controller
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_checker #(
  parameter int STOP_LIMIT = 64
) (
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic        HREADY_IN,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        INTERRUPT_IN,
  input wire logic        GLOBAL_INTERRUPT_ENABLE_IN,
  input wire logic        PC_STALL_OUT,
  input wire logic        BUSY_OUT,
  input wire logic        TIMING_CLK_REQ_OUT,
  input wire logic        FLASH_ERASE_OUT,
  input wire logic        FLASH_WRITE_OUT,
  input wire logic [15:0] FLASH_ADDR_OUT
);
  logic take;       // write address phase accepted
  logic third_r;    // data phase of a third control write
  logic first_r;    // data phase of a first control write
  logic susp_r;     // suspend option held
  logic abt_r;      // abort option held
  logic lock_r;     // segment lock held
  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
  // remember which register the data phase belongs to
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      third_r <= 1'b0;
      first_r <= 1'b0;
    end else if (HREADY_IN) begin
      third_r <= take && (HADDR_IN == 32'h08);
      first_r <= take && (HADDR_IN == 32'h00);
    end
  end
  // option and lock bits land at the end of their data phase
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      susp_r <= 1'b0;
      abt_r  <= 1'b0;
      lock_r <= 1'b1;
    end else begin
      if (first_r) begin
        susp_r <= HWDATA_IN[2];
        abt_r  <= HWDATA_IN[3];
      end
      if (third_r) begin
        lock_r <= HWDATA_IN[2];
      end
    end
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  bus_okay_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not ready and okay");
  stall_busy_a: assert property (PC_STALL_OUT |-> BUSY_OUT && FLASH_ERASE_OUT)
    else $error("stall without running erase");
  erase_stall_a: assert property ($rose(FLASH_ERASE_OUT) |-> BUSY_OUT && PC_STALL_OUT)
    else $error("erase started without busy and stall");
  clk_req_a: assert property (TIMING_CLK_REQ_OUT |-> BUSY_OUT)
    else $error("timing clock held after operation");
  lock_guard_a: assert property ((FLASH_WRITE_OUT || FLASH_ERASE_OUT) && lock_r |->
    (FLASH_ADDR_OUT & 16'hffc0) != 16'h10c0) else $error("locked segment touched");
  exit_ends_a: assert property (third_r && HWDATA_IN[1] |-> ##[1:3] !BUSY_OUT)
    else $error("exit did not end operation");
  susp_halt_a: assert property ($rose(INTERRUPT_IN) && PC_STALL_OUT && susp_r && !abt_r
    |-> ##[2:6] (BUSY_OUT && !PC_STALL_OUT)) else $error("erase not suspended");
  int_abort_a: assert property ($rose(INTERRUPT_IN) && BUSY_OUT && abt_r && GLOBAL_INTERRUPT_ENABLE_IN
    |-> ##[2:6] !BUSY_OUT) else $error("interrupt did not abort");
  addr_hold_a: assert property (BUSY_OUT && $past(BUSY_OUT) |-> $stable(FLASH_ADDR_OUT))
    else $error("address moved during operation");
endmodule // flash_ctl_checker
bind flash_erase_write_control flash_ctl_checker #(.STOP_LIMIT(STOP_LIMIT)) chk_u (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .INTERRUPT_IN(INTERRUPT_IN),
  .GLOBAL_INTERRUPT_ENABLE_IN(GLOBAL_INTERRUPT_ENABLE_IN), .PC_STALL_OUT(PC_STALL_OUT),
  .BUSY_OUT(BUSY_OUT), .TIMING_CLK_REQ_OUT(TIMING_CLK_REQ_OUT), .FLASH_ERASE_OUT(FLASH_ERASE_OUT),
  .FLASH_WRITE_OUT(FLASH_WRITE_OUT), .FLASH_ADDR_OUT(FLASH_ADDR_OUT));
`default_nettype wire

// [tb/core_model.sv]
// behavioural core side: interrupt source, return and flash timing clock
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic clk_in,
  input  wire logic fire_in,   // raise one interrupt
  input  wire logic gie_in,    // global interrupt enable
  input  wire logic req_in,    // timing clock request
  input  wire logic halt_in,   // oscillator fault
  output logic      irq_out,
  output logic      reti_out,
  output logic      tclk_out
);
  int age = 99;  // cycles since last interrupt
  initial begin
    irq_out = 1'b0;
    reti_out = 1'b0;
    tclk_out = 1'b0;
  end
  // clock runs only while requested, stands still otherwise
  always #8 tclk_out <= (req_in && !halt_in) ? ~tclk_out : 1'b0;
  // interrupt level for a few cycles, service, then return
  always @(posedge clk_in) begin
    age <= fire_in ? 0 : ((age < 99) ? age + 1 : age);
    irq_out <= fire_in || (age < 3);
    reti_out <= gie_in && (age >= 40) && (age < 44);
  end
endmodule // core_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the flash erase and write controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic        global_interrupt_enable = 1'b0, fire = 1'b0, halt = 1'b0, hready, hresp, tclk, irq, reti;
  logic        stall, busy, creq, fwr, fer, marg;
  logic [15:0] faddr, a;
  logic [7:0]  fdata, d;
  int          num_errors = 0, tests_run = 0;
  always #2 clk_sys = ~clk_sys;
  flash_erase_write_control #(.STOP_LIMIT(8)) dut_u (
    .CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .TIMING_CLK_IN(tclk), .INTERRUPT_IN(irq),
    .GLOBAL_INTERRUPT_ENABLE_IN(global_interrupt_enable), .RETURN_FROM_INTERRUPT_IN(reti), .PC_STALL_OUT(stall),
    .BUSY_OUT(busy), .TIMING_CLK_REQ_OUT(creq), .FLASH_WRITE_OUT(fwr), .FLASH_ERASE_OUT(fer),
    .FLASH_ADDR_OUT(faddr), .FLASH_DATA_OUT(fdata), .MARGINAL_READ_OUT(marg));
  core_model core_u (.clk_in(clk_sys), .fire_in(fire), .gie_in(global_interrupt_enable), .req_in(creq), .halt_in(halt),
    .irq_out(irq), .reti_out(reti), .tclk_out(tclk));
  // expected third control word
  function automatic logic [31:0] status(input logic bz, lk, sp, ab, cr);
    return {26'h0, cr, ab, sp, lk, 1'b0, bz};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // single word transfer, holds each phase until hready
  task automatic bus(input logic w, input logic [31:0] adr, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= adr;
    hwrite <= w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dat;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  // address, options, then the byte dummy write that starts it
  task automatic start(input logic [15:0] adr, input logic [31:0] ctl, input logic [7:0] dat);
    bus(1'b1, 32'h0c, {16'h0, adr});
    bus(1'b1, 32'h00, ctl);
    bus(1'b1, 32'h10, {24'h0, dat});
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) @(posedge clk_sys);
    if (busy !== 1'b0) begin
      num_errors++;
      $display("MISMATCH t=%0t operation never finished", $time);
    end
  endtask
  task automatic pulse_int;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask
  task automatic done(input string name);
    $display("test %s done, mismatches %0d", name, num_errors);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog on a hung wait
  initial begin
    #300us;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h4962149d));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 32'h08, 32'h0);
    chk(rd, status(0, 1, 0, 0, 0), "reset status");
    bus(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    done("reset");
    bus(1'b1, 32'h08, 32'h0);
    // back to back byte writes at random places
    for (int k = 0; k < 4; k++) begin
      a = 16'h8000 | 16'($urandom_range(16'h3fff));
      d = 8'($urandom);
      start(a, 32'h1, d);
      chk(32'({fwr, busy, creq}), 32'h7, "write running");
      chk(32'({faddr, fdata}), 32'({a, d}), "write target");
      wait_idle(400);
      chk(32'({busy, creq}), 32'h0, "write released");
    end
    done("write");
    global_interrupt_enable <= 1'b1;
    a = 16'hc000 + 16'(2 * $urandom_range(200));
    start(a, 32'h16, 8'hff);
    chk(32'({marg, stall}), 32'h3, "marginal erase stall");
    bus(1'b0, 32'h08, 32'h0);
    chk(rd, status(1, 0, 0, 0, 1), "erase status");
    pulse_int();
    repeat (12) @(posedge clk_sys);
    chk(32'({busy, stall}), 32'h2, "suspended");
    bus(1'b0, 32'h08, 32'h0);
    chk(rd, status(1, 0, 1, 0, 0), "suspend status");
    repeat (40) @(posedge clk_sys);
    chk(32'({stall, faddr}), 32'({1'b1, a}), "resumed");
    wait_idle(20000);
    chk(32'({busy, stall}), 32'h0, "erase end");
    done("suspend");
    start(16'h8000 | 16'($urandom_range(16'h3fff)), 32'h1, 8'($urandom));
    repeat (5) @(posedge clk_sys);
    bus(1'b1, 32'h08, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk(32'(busy), 32'h0, "exit ends");
    bus(1'b0, 32'h08, 32'h0);
    chk(rd & 32'h11, 32'h10, "exit flag");
    repeat (20) @(posedge clk_sys);
    done("exit");
    bus(1'b1, 32'h08, 32'h4);
    start(16'h10c0 + 16'(2 * $urandom_range(31)), 32'h2, 8'hff);
    chk(32'({busy, fer}), 32'h0, "locked refused");
    bus(1'b1, 32'h08, 32'h0);
    done("lock");
    start(16'hc000, 32'h0a, 8'hff);
    repeat (10) @(posedge clk_sys);
    pulse_int();
    repeat (10) @(posedge clk_sys);
    chk(32'(busy), 32'h0, "interrupt abort");
    repeat (1520) @(posedge clk_sys);
    done("abort");
    start(16'hc000, 32'h2, 8'hff);
    repeat (10) @(posedge clk_sys);
    halt <= 1'b1;
    repeat (25) @(posedge clk_sys);
    chk(32'({busy, creq}), 32'h0, "clock fault");
    halt <= 1'b0;
    done("fault");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
